// ### core/adc_ctrl_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   conversion times are given in fc cycles
`default_nettype none
package adc_ctrl_pkg;
   // register offsets
   localparam logic [7:0] ctrl_one_off  = 8'h26;
   localparam logic [7:0] ctrl_two_off  = 8'h27;
   localparam logic [7:0] res_low_off   = 8'h28;
   localparam logic [7:0] res_high_off  = 8'h29;
   // control one fields
   localparam int start_pos   = 7;
   localparam int mode_lsb    = 5;
   localparam int indis_pos   = 4;
   localparam int chan_lsb    = 0;
   // control two fields
   localparam int ladder_pos  = 5;
   localparam int ctime_lsb   = 1;
   // result low fields
   localparam int res_lo_lsb  = 6;
   localparam int eoc_pos     = 5;
   localparam int busy_pos    = 4;
   // reset values
   localparam logic [7:0] ctrl_one_rst = 8'h10;
   localparam logic [7:0] ctrl_two_rst = 8'h10;
   localparam logic [7:0] res_rst      = 8'h00;
   // start lockout after control one cleared to zero
   localparam int         lockout_cycles = 4;
   // conversion times in fc cycles
   localparam logic [10:0] ct_39   = 11'd39;
   localparam logic [10:0] ct_78   = 11'd78;
   localparam logic [10:0] ct_156  = 11'd156;
   localparam logic [10:0] ct_312  = 11'd312;
   localparam logic [10:0] ct_624  = 11'd624;
   localparam logic [10:0] ct_1248 = 11'd1248;

   typedef enum logic [1:0] {
      mode_off    = 2'b00,
      mode_soft   = 2'b01,
      mode_resv   = 2'b10,
      mode_repeat = 2'b11
   } op_mode_t;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // conversion time code to cycle count; reserved codes use the longest
   function automatic logic [10:0] ctime_cycles(input logic [2:0] code);
      case (code)
         3'b000:  ctime_cycles = ct_39;
         3'b010:  ctime_cycles = ct_78;
         3'b011:  ctime_cycles = ct_156;
         3'b100:  ctime_cycles = ct_312;
         3'b101:  ctime_cycles = ct_624;
         default: ctime_cycles = ct_1248;
      endcase
   endfunction
endpackage
`default_nettype wire

// ### core/conv_timer.sv
// Purpose: counts the cycles of one conversion
// Assumes: load is a one-cycle pulse; abort may be held for several cycles
// Notes:   done pulses once when the selected count has elapsed
`timescale 1ns/1ps
`default_nettype none
module conv_timer #(
   parameter int CW = 11
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          load,
   input  wire logic          abort,
   input  wire logic [CW-1:0] cycles,
   output logic               done
);
   logic [CW-1:0] cnt_ff;
   logic          run_ff;

   ////////////////////////////////////////////////////////////////////////
   // count up from one to the selected length
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
      end else if (abort) begin
         run_ff <= 1'b0;
         cnt_ff <= '0;
      end else if (load) begin
         run_ff <= 1'b1;
         cnt_ff <= CW'(1);
      end else if (run_ff) begin
         if (cnt_ff == cycles) begin
            run_ff <= 1'b0;
         end
         cnt_ff <= cnt_ff + CW'(1);
      end
   end

   // done when the selected count is reached; load is left out on purpose,
   // since a repeat relaunch is itself derived from done (loop hazard)
   assign done = run_ff && (cnt_ff == cycles) && !abort;
endmodule // conv_timer
`default_nettype wire

// ### core/adc_sequencer_result_regs.sv
// Purpose: control and result registers of a 10-bit converter sequencer
// Assumes: plain register port, read data one cycle after read strobe
// Notes:   analog core is outside; this block times and stores results
// Function
// - result split: high eight, low two bits
// - end flag set with result store
// - interrupt pulse with end flag
// - reading result high clears end flag
// - busy set at start, cleared end/stop
// - result low bits 3..0 undefined
// - software mode start converts chosen channel
// - start bit self-clears after conversion begins
// - repeat mode relaunches after each completion
// - mode off halts, result discarded
// - new start clears flag, keeps old result
// - store only after full conversion time
// - stop aborts, resets controls, clears results
// - after stop stay idle until start
// - stop disconnects reference ladder
// - conversion time code encodings
// - control one bit layout
// - ladder bit: during conversion or always
// - starts ignored four cycles after zero write; here a start bit written then is held and launches when the lockout ends
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_result_regs #(
   parameter int RES_W = 10
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire adc_ctrl_pkg::reg_req_t req,
   output logic [7:0]                  rdata,
   input  wire logic                   stop_mode,
   input  wire logic [RES_W-1:0]       sar_value,
   output logic                        conversion_done_irq,
   output logic                        sample_start,
   output logic [3:0]                  channel_select_field,
   output logic                        analog_input_disable,
   output logic                        ladder_connect,
   output logic                        converter_busy_flag
);
   import adc_ctrl_pkg::*;

   logic [7:0]       ctrl_one_ff;
   logic [7:0]       ctrl_two_ff;
   logic [7:0]       result_high_reg_ff;
   logic [1:0]       result_low_ff;
   logic             eoc_ff;
   logic             busy_ff;
   logic [2:0]       lock_ff;
   logic             stop_ff;
   logic [7:0]       rdata_ff;
   logic             irq_ff;
   logic             samp_ff;
   logic             ladder_ff;
   logic             timer_done;
   logic             launch;
   logic             halt;
   logic             store;
   logic             wr_one;
   logic             wr_two;
   logic             rd_high;
   op_mode_t         mode;
   logic [7:0]       nxt_rdata;

   ////////////////////////////////////////////////////////////////////////
   // decode
   assign wr_one  = req.wr && (req.addr == ctrl_one_off);
   assign wr_two  = req.wr && (req.addr == ctrl_two_off);
   assign rd_high = req.rd && (req.addr == res_high_off);
   assign mode    = op_mode_t'(ctrl_one_ff[mode_lsb +: 2]);

   // a launch needs the start bit in soft or repeat mode, no lockout;
   // in repeat mode a completion relaunches at once
   assign launch = !stop_mode && !stop_ff && !busy_ff && lock_ff == 3'd0
                   && ctrl_one_ff[start_pos]
                   && (mode == mode_soft || mode == mode_repeat)
                   || (!stop_mode && timer_done && mode == mode_repeat
                       && !halt);
   // writing mode off stops a running conversion without a store
   assign halt  = busy_ff && (mode == mode_off);
   assign store = timer_done && !halt && !stop_mode;

   conv_timer #(
      .CW (11)
   ) u_timer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .load    (launch),
      .abort   (halt || stop_mode),
      .cycles  (ctime_cycles(ctrl_two_ff[ctime_lsb +: 3])),
      .done    (timer_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // control register one; writes are blocked while stop holds it in reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_one_ff <= ctrl_one_rst;
      end else if (stop_mode) begin
         ctrl_one_ff <= ctrl_one_rst;
      end else if (wr_one) begin
         ctrl_one_ff <= req.wdata;
      end else if (launch) begin
         ctrl_one_ff[start_pos] <= 1'b0;
      end
   end

   // control register two; fixed bits forced
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_two_ff <= ctrl_two_rst;
      end else if (stop_mode) begin
         ctrl_two_ff <= ctrl_two_rst;
      end else if (wr_two) begin
         ctrl_two_ff <= {2'b00, req.wdata[5], 1'b1, req.wdata[3:1], 1'b0};
      end
   end

   // start lockout after control one written with zero
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_ff <= 3'd0;
      end else if (wr_one && req.wdata == 8'h00) begin
         lock_ff <= 3'(lockout_cycles);
      end else if (lock_ff != 3'd0) begin
         lock_ff <= lock_ff - 3'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // busy flag
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
      end else if (stop_mode || halt) begin
         busy_ff <= 1'b0;
      end else if (launch) begin
         busy_ff <= 1'b1;
      end else if (timer_done) begin
         busy_ff <= 1'b0;
      end
   end

   // end flag: store wins over the read clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         eoc_ff <= 1'b0;
      end else if (stop_mode) begin
         eoc_ff <= 1'b0;
      end else if (store) begin
         eoc_ff <= 1'b1;
      end else if (launch || rd_high) begin
         eoc_ff <= 1'b0;
      end
   end

   // results kept until the next store; stop clears them
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_high_reg_ff <= res_rst;
         result_low_ff      <= 2'b00;
      end else if (stop_mode) begin
         result_high_reg_ff <= res_rst;
         result_low_ff      <= 2'b00;
      end else if (store) begin
         result_high_reg_ff <= sar_value[RES_W-1 -: 8];
         result_low_ff      <= sar_value[1:0];
      end
   end

   // interrupt pulse and sample strobe
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff  <= 1'b0;
         samp_ff <= 1'b0;
      end else begin
         irq_ff  <= store;
         samp_ff <= launch;
      end
   end

   // ladder: always when set, else only while converting; off in stop
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ladder_ff <= 1'b0;
      end else if (stop_mode) begin
         ladder_ff <= 1'b0;
      end else begin
         ladder_ff <= ctrl_two_ff[ladder_pos] || launch
                      || (busy_ff && !halt && !timer_done);
      end
   end

   // stop seen last cycle, so idle is held after wake
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_ff <= 1'b0;
      end else begin
         stop_ff <= stop_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; low nibble of result low reads zero
   always_comb begin
      nxt_rdata = 8'h00;
      unique case (req.addr)
         ctrl_one_off: nxt_rdata = ctrl_one_ff;
         ctrl_two_off: nxt_rdata = {2'b00, ctrl_two_ff[5:0]};
         res_low_off:  nxt_rdata = {result_low_ff, eoc_ff, busy_ff,
                                    4'h0};
         res_high_off: nxt_rdata = result_high_reg_ff;
         default:      nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else if (req.rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign rdata                = rdata_ff;
   assign conversion_done_irq  = irq_ff;
   assign sample_start         = samp_ff;
   assign channel_select_field = ctrl_one_ff[chan_lsb +: 4];
   assign analog_input_disable = ctrl_one_ff[indis_pos];
   assign ladder_connect       = ladder_ff;
   assign converter_busy_flag  = busy_ff;
endmodule // adc_sequencer_result_regs
`default_nettype wire

// ### testbench/adc_seq_checker.sv
// Purpose: port assertions for the converter sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker
   import adc_ctrl_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire reg_req_t   req,
   input wire logic [7:0] rdata,
   input wire logic       stop_mode,
   input wire logic       conversion_done_irq,
   input wire logic       sample_start,
   input wire logic [3:0] channel_select_field,
   input wire logic       analog_input_disable,
   input wire logic       ladder_connect,
   input wire logic       converter_busy_flag
);
   logic [10:0] since_ff;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // cycles since the last launch, saturating so it never wraps
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) since_ff <= 11'h000;
      else if (sample_start) since_ff <= 11'h000;
      else if (since_ff != 11'h7ff) since_ff <= since_ff + 11'h001;
   end
   ////////////////////////////////////////////////////////////////////
   a_irq_one_pulse: assert property (conversion_done_irq |=>
      !conversion_done_irq) else $error("irq longer than one cycle");
   a_irq_after_busy: assert property (conversion_done_irq |->
      $past(converter_busy_flag, 3)) else $error("irq without busy");
   a_irq_full_time: assert property (conversion_done_irq |->
      since_ff >= 11'd37) else $error("result stored too early");
   a_start_sets_busy: assert property (sample_start |->
      ##[0:2] converter_busy_flag) else $error("busy not set");
   a_stop_ladder_off: assert property (stop_mode ##1 stop_mode |->
      !ladder_connect) else $error("ladder on in stop");
   a_stop_ctrl_init: assert property (stop_mode ##1 stop_mode |->
      analog_input_disable && channel_select_field == 4'h0 &&
      !converter_busy_flag) else $error("stop did not reset");
   a_stop_no_start: assert property (stop_mode ##1 stop_mode |->
      !sample_start) else $error("launch during stop");
   a_mode_off_halts: assert property (req.wr &&
      req.addr == ctrl_one_off && req.wdata[6:5] == 2'b00 |->
      ##[1:3] !converter_busy_flag) else $error("mode off kept busy");
   a_low_nibble_zero: assert property ($past(req.rd) &&
      $past(req.addr) == res_low_off |-> rdata[3:0] == 4'h0)
      else $error("low nibble not zero");
   c_irq: cover property (conversion_done_irq);
   c_stop_busy: cover property (stop_mode && converter_busy_flag);
   c_relaunch: cover property (sample_start && converter_busy_flag);
endmodule // adc_seq_checker
bind adc_sequencer_result_regs adc_seq_checker i_adc_seq_checker (
   .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
   .stop_mode(stop_mode), .conversion_done_irq(conversion_done_irq),
   .sample_start(sample_start),
   .channel_select_field(channel_select_field),
   .analog_input_disable(analog_input_disable),
   .ladder_connect(ladder_connect),
   .converter_busy_flag(converter_busy_flag));
`default_nettype wire

// ### testbench/test_adc_sequencer_result_regs.sv
// Purpose: register-level tests of the converter sequencer
// Assumes: read data stands the cycle after the read strobe
// Notes:   conversion times run at full length, about 5k cycles
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequencer_result_regs;
   import adc_ctrl_pkg::*;
   logic       ref_clk = 1'b0;
   logic       rst_n   = 1'b0;
   reg_req_t   req     = '0;
   logic       stop_mode = 1'b0;
   logic [9:0] sar     = 10'h2d6;
   logic [7:0] rdata;
   logic       irq, sst, indis, ladder, busy;
   logic [3:0] chan;
   int         error_cnt = 0;
   int         n_compared = 0;
   int         cyc = 0;
   int         n;
   logic [2:0] codes [6] = '{3'b000, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110};
   int         tcyc [6] = '{39, 78, 156, 312, 624, 1248};
   adc_sequencer_result_regs i_adc_sequencer_result_regs (
      .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
      .stop_mode(stop_mode), .sar_value(sar), .conversion_done_irq(irq),
      .sample_start(sst), .channel_select_field(chan),
      .analog_input_disable(indis), .ladder_connect(ladder),
      .converter_busy_flag(busy));
   always #4 ref_clk = ~ref_clk;
   // hang guard: the whole sequence needs well under 20k cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [7:0] e,
                      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask
   // read strobe one cycle, then look at the data standing after it
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1 chk(s, e, rdata);
   endtask
   task automatic wait_irq(output int k);
      k = 0;
      do begin
         @(posedge ref_clk);
         #1 k++;
      end while (irq !== 1'b1 && k < 2000);
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(8'h26, 8'h10, "ctrl one");
      rd(8'h27, 8'h10, "ctrl two");
      rd(8'h28, 8'h00, "res low");
      rd(8'h29, 8'h00, "res high");
      rd(8'h30, 8'h00, "unmapped");
      $display("test reset values done");
      // unread results between runs: each new start clears the flag
      foreach (codes[i]) begin
         wr(8'h27, {4'h1, codes[i], 1'b0});
         wr(8'h26, 8'ha5);
         wait_irq(n);
         chk("ctime", 8'h01, 8'(n >= tcyc[i] && n <= tcyc[i] + 6));
      end
      chk("chan", 8'h05, {4'h0, chan});
      rd(8'h26, 8'h25, "start cleared");
      rd(8'h28, 8'ha0, "low flag");
      rd(8'h29, 8'hb5, "high");
      rd(8'h28, 8'h80, "flag cleared");
      $display("test software start done");
      wr(8'h27, 8'h10);
      sar <= 10'h135;
      wr(8'h26, 8'he3);
      wait_irq(n);
      sar <= 10'h0ca;
      repeat (4) @(posedge ref_clk);
      #1 chk("busy repeat", 8'h01, {7'h0, busy});
      chk("ladder conv", 8'h01, {7'h0, ladder});
      rd(8'h28, 8'h70, "old low kept");
      rd(8'h29, 8'h4d, "old high kept");
      wait_irq(n);
      chk("second irq", 8'h01, 8'(n < 2000));
      sar <= 10'h3ff;
      repeat (10) @(posedge ref_clk);
      wr(8'h26, 8'h03);
      repeat (60) @(posedge ref_clk);
      #1 chk("halt busy", 8'h00, {7'h0, busy});
      rd(8'h29, 8'h32, "halt high");
      rd(8'h28, 8'h80, "halt low");
      $display("test repeat done");
      wr(8'h26, 8'h00);
      wr(8'h26, 8'ha5);
      repeat (2) @(posedge ref_clk);
      #1 chk("lockout", 8'h00, {7'h0, busy});
      wait_irq(n);
      chk("pending start", 8'h01, 8'(n < 2000));
      chk("ladder idle", 8'h00, {7'h0, ladder});
      // reserved mode must not start even with the start bit set
      wr(8'h26, 8'hc5);
      repeat (4) @(posedge ref_clk);
      #1 chk("mode resv", 8'h00, {7'h0, busy});
      $display("test lockout done");
      wr(8'h27, 8'h30);
      @(posedge ref_clk);
      #1 chk("ladder always", 8'h01, {7'h0, ladder});
      wr(8'h26, 8'ha5);
      rd(8'h28, 8'hd0, "restart clears flag");
      repeat (10) @(posedge ref_clk);
      @(posedge ref_clk);
      stop_mode <= 1'b1;
      wr(8'h26, 8'ha5);
      repeat (3) @(posedge ref_clk);
      #1 chk("stop busy", 8'h00, {7'h0, busy});
      chk("stop ladder", 8'h00, {7'h0, ladder});
      chk("stop ctrl", 8'h10, {3'h0, indis, chan});
      @(posedge ref_clk);
      stop_mode <= 1'b0;
      wait_irq(n);
      chk("no restart", 8'h01, 8'(n == 2000));
      rd(8'h26, 8'h10, "ctrl one init");
      rd(8'h27, 8'h10, "ctrl two init");
      rd(8'h28, 8'h00, "low lost");
      rd(8'h29, 8'h00, "high lost");
      $display("test stop done");
      wrap_up();
   end
endmodule // test_adc_sequencer_result_regs
`default_nettype wire
